//--- lpcg_cpu_model.sv
`timescale 1ns/1ps
// ****************************************
// CPU side: counts delivered clock pulses
// ****************************************
module lpcg_cpu_model (
   input wire logic ref_clk,
   input wire logic phi,
   input wire logic clr,
   output logic [15:0] pulses
);
   logic phi_q;
   // Phi is far slower than the sampling clock, so no pulse is missed
   always_ff @(posedge ref_clk) begin
      phi_q <= phi;
      if (clr) pulses <= 16'h0000;
      else if (phi && !phi_q) pulses <= pulses + 16'h0001;
   end
endmodule

//--- lpcg_pkg.sv
// Behaviour
// - Stop holds clock high, all oscillators off.
// - Select 0: stop loads prescaler FF, timer 01.
// - Select 1: stop leaves prescaler, timer untouched.
// - Prescaler counts selected source divided by 16.
// - Interrupt restarts oscillator; clock after underflow.
// - Reset leaves stop with no wait.
// - Wait holds clock high, oscillators keep running.
// - Wait resumes at once on interrupt or reset.
// - Auto bit: I2C pin edge starts main, middle.
// - Wait select picks 5 or 7 low cycles.
// - Auto write in middle starts main oscillator.
// - Middle speed is source over 8; reset default.
// - Low speed is source over 2.
package lpcg_pkg;
   // ****************************************
   // Stabilisation counters
   // ****************************************
   localparam int STAB_W = 8;
   localparam logic [STAB_W-1:0] PRE_INIT = 8'hFF;
   localparam logic [STAB_W-1:0] TMR_INIT = 8'h01;
   localparam logic [STAB_W-1:0] CNT_ONE = 8'h01;
   localparam logic [STAB_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [3:0] SRC_DIV_LAST = 4'hF;
   // ****************************************
   // Clock division and automatic switch
   // ****************************************
   localparam logic [1:0] MID_HALF_LAST = 2'h3;
   localparam logic [2:0] AUTO_WAIT_SHORT = 3'h5;
   localparam logic [2:0] AUTO_WAIT_LONG = 3'h7;
   localparam int SYNC_W = 5;
   localparam int SYNC_RC = 0;
   localparam int SYNC_MAIN = 1;
   localparam int SYNC_SUB = 2;
   localparam int SYNC_SCL = 3;
   localparam int SYNC_SDA = 4;
   typedef enum logic [1:0] {LPCG_RUN, LPCG_STOP, LPCG_STAB, LPCG_WAIT} lpcg_state_t;
endpackage

//--- lpcg_sva.sv
`timescale 1ns/1ps
module lpcg_sva (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic irq_accepted,
   input wire logic stab_select,
   input wire logic phi,
   input wire logic rc_osc_en,
   input wire logic main_osc_en,
   input wire logic sub_osc_en,
   input wire logic mid_speed,
   input wire logic stop_active,
   input wire logic wait_active,
   input wire logic tmr_underflow,
   input wire logic [lpcg_pkg::STAB_W-1:0] stab_pre,
   input wire logic [lpcg_pkg::STAB_W-1:0] stab_tmr
);
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   logic [2:0] osc;
   assign osc = {rc_osc_en, main_osc_en, sub_osc_en};
   a_stop_osc_off: assert property ($rose(stop_active) |-> osc == 3'h0)
      else $error("oscillator running in stop");
   a_stop_phi_high: assert property (stop_active |-> phi)
      else $error("clock low during stop");
   a_stop_preload: assert property ($rose(stop_active) && !stab_select |->
      stab_pre == 8'hFF && stab_tmr == 8'h01)
      else $error("stop preload wrong");
   a_stop_keep: assert property ($rose(stop_active) && stab_select |->
      $stable(stab_pre) && $stable(stab_tmr))
      else $error("stop changed counters");
   a_uf_release: assert property (tmr_underflow |-> !stop_active ##1 !tmr_underflow)
      else $error("underflow did not end stop");
   // Reset has no disable here: it is the cause under test
   a_reset_vals: assert property (disable iff (1'b0) !rst_b |=> phi && mid_speed
      && rc_osc_en && !main_osc_en && !stop_active && !wait_active)
      else $error("reset state wrong");
   a_wait_phi_high: assert property (wait_active |-> phi)
      else $error("clock low during wait");
   a_wait_osc_keep: assert property ($rose(wait_active) |-> $stable(osc))
      else $error("wait changed oscillators");
   a_wait_wake: assert property (wait_active && irq_accepted |-> ##[1:2] !wait_active)
      else $error("wait not left");
   a_gate_no_runt: assert property ($rose(stop_active | wait_active) |-> $past(phi))
      else $error("gate closed while clock low");
   c_stop: cover property ($rose(stop_active));
   c_underflow: cover property (tmr_underflow);
   c_wait: cover property ($rose(wait_active));
   c_low: cover property ($fell(mid_speed));
endmodule
bind lpcg_top lpcg_sva u_lpcg_sva (
   .ref_clk(ref_clk), .rst_b(rst_b), .irq_accepted(irq_accepted), .stab_select(stab_select),
   .phi(phi), .rc_osc_en(rc_osc_en), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
   .mid_speed(mid_speed), .stop_active(stop_active), .wait_active(wait_active),
   .tmr_underflow(tmr_underflow), .stab_pre(stab_pre), .stab_tmr(stab_tmr)
);

//--- lpcg_sync.sv
`timescale 1ns/1ps
module lpcg_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] any_edge
);
   // ****************************************
   // Three stages; a change counts when stages two and three agree
   // ****************************************
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
      logic [WIDTH-1:0] primed;
      logic [2:0] fill;
   } lpcg_sync_t;
   lpcg_sync_t r, next_r;
   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("lpcg_sync: WIDTH must be at least 1");
      end
   endgenerate
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         assign rise[i] = r.primed[i] && (r.s2[i] == r.s3[i]) && r.s3[i] && !r.lvl[i];
         assign any_edge[i] = r.primed[i] && (r.s2[i] == r.s3[i]) && (r.s3[i] != r.lvl[i]);
         assign level[i] = r.lvl[i];
      end
   endgenerate
   always_comb begin
      next_r = r;
      next_r.s1 = pin;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      // First settled value loads silently, so a pin idling high gives no edge after reset
      next_r.fill = {r.fill[1:0], 1'b1};
      for (int k = 0; k < WIDTH; k++) begin
         if (r.fill[2] && r.s2[k] == r.s3[k]) begin
            next_r.lvl[k] = r.s3[k];
            next_r.primed[k] = 1'b1;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule

//--- lpcg_top.sv
`timescale 1ns/1ps
module lpcg_top (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic rc_osc_clk,
   input wire logic main_osc_input,
   input wire logic sub_osc_input,
   input wire logic scl_pin,
   input wire logic sda_pin,
   input wire logic stop_instruction,
   input wire logic wait_instruction,
   input wire logic ext_irq,
   input wire logic irq_accepted,
   input wire logic stab_select,
   input wire logic auto_mid_write,
   input wire logic auto_mid_value,
   input wire logic auto_wait_long,
   input wire logic rc_source_sel,
   input wire logic rc_osc_on,
   input wire logic sub_osc_on,
   input wire logic main_start,
   input wire logic main_stop,
   input wire logic go_low_speed,
   input wire logic go_mid_speed,
   input wire logic stab_load,
   input wire logic [lpcg_pkg::STAB_W-1:0] stab_pre_value,
   input wire logic [lpcg_pkg::STAB_W-1:0] stab_tmr_value,
   output logic phi,
   output logic rc_osc_en,
   output logic main_osc_en,
   output logic sub_osc_en,
   output logic mid_speed,
   output logic stop_active,
   output logic wait_active,
   output logic tmr_underflow,
   output logic [lpcg_pkg::STAB_W-1:0] stab_pre,
   output logic [lpcg_pkg::STAB_W-1:0] stab_tmr
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      lpcg_pkg::lpcg_state_t st;
      logic stop_pend;
      logic wait_pend;
      logic phi;
      logic [1:0] half;
      logic [3:0] div16;
      logic [lpcg_pkg::STAB_W-1:0] pre;
      logic [lpcg_pkg::STAB_W-1:0] tmr;
      logic uflow;
      logic mid;
      logic auto_en;
      logic auto_run;
      logic [2:0] auto_cnt;
      logic main_req;
      logic rc_en;
      logic main_en;
      logic sub_en;
      logic stop_out;
      logic wait_out;
   } lpcg_core_t;
   lpcg_core_t r, next_r;
   logic [lpcg_pkg::SYNC_W-1:0] sync_rise, sync_edge;
   logic src_tick;
   logic i2c_edge;
   logic [2:0] auto_goal;

   // ****************************************
   // Pin sampling
   // ****************************************
   lpcg_sync #(.WIDTH(lpcg_pkg::SYNC_W)) u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .pin({sda_pin, scl_pin, sub_osc_input, main_osc_input, rc_osc_clk}),
      .level(),
      .rise(sync_rise),
      .any_edge(sync_edge)
   );

   // Middle speed runs from RC or main, low speed from RC or sub
   always_comb begin
      if (rc_source_sel) begin
         src_tick = sync_rise[lpcg_pkg::SYNC_RC];
      end else if (r.mid) begin
         src_tick = sync_rise[lpcg_pkg::SYNC_MAIN];
      end else begin
         src_tick = sync_rise[lpcg_pkg::SYNC_SUB];
      end
   end
   assign i2c_edge = sync_edge[lpcg_pkg::SYNC_SCL] | sync_edge[lpcg_pkg::SYNC_SDA];
   assign auto_goal = auto_wait_long ? lpcg_pkg::AUTO_WAIT_LONG
                                     : lpcg_pkg::AUTO_WAIT_SHORT;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_r = r;
      next_r.uflow = 1'b0;
      // Internal clock divider; frozen high outside RUN
      if (r.st == lpcg_pkg::LPCG_RUN && src_tick) begin
         if (!r.mid) begin
            next_r.phi = !r.phi;
         end else if (r.half == lpcg_pkg::MID_HALF_LAST) begin
            next_r.half = '0;
            next_r.phi = !r.phi;
         end else begin
            next_r.half = r.half + 2'h1;
         end
      end
      if (stop_instruction) begin
         next_r.stop_pend = 1'b1;
      end
      if (wait_instruction) begin
         next_r.wait_pend = 1'b1;
      end
      if (stab_load) begin
         next_r.pre = stab_pre_value;
         next_r.tmr = stab_tmr_value;
      end
      case (r.st)
         lpcg_pkg::LPCG_RUN: begin
            // Gate closes only on a high phase so no runt pulse reaches the CPU
            if (r.stop_pend && r.phi) begin
               next_r.st = lpcg_pkg::LPCG_STOP;
               next_r.stop_pend = 1'b0;
               next_r.phi = 1'b1;
               next_r.half = '0;
               next_r.div16 = '0;
               if (!stab_select) begin
                  next_r.pre = lpcg_pkg::PRE_INIT;
                  next_r.tmr = lpcg_pkg::TMR_INIT;
               end
            end else if (r.wait_pend && r.phi) begin
               next_r.st = lpcg_pkg::LPCG_WAIT;
               next_r.wait_pend = 1'b0;
               next_r.phi = 1'b1;
               next_r.half = '0;
            end
         end
         lpcg_pkg::LPCG_STOP: begin
            if (ext_irq) begin
               next_r.st = lpcg_pkg::LPCG_STAB;
            end
         end
         lpcg_pkg::LPCG_STAB: begin
            // Count only once the restarted source is ticking
            if (src_tick) begin
               next_r.div16 = r.div16 + 4'h1;
               if (r.div16 == lpcg_pkg::SRC_DIV_LAST) begin
                  next_r.pre = r.pre - lpcg_pkg::CNT_ONE;
                  if (r.pre == lpcg_pkg::CNT_ZERO) begin
                     next_r.tmr = r.tmr - lpcg_pkg::CNT_ONE;
                     if (r.tmr == lpcg_pkg::CNT_ZERO) begin
                        next_r.st = lpcg_pkg::LPCG_RUN;
                        next_r.uflow = 1'b1;
                     end
                  end
               end
            end
         end
         lpcg_pkg::LPCG_WAIT: begin
            if (irq_accepted || ext_irq) begin
               next_r.st = lpcg_pkg::LPCG_RUN;
            end
         end
         default: begin
            next_r.st = lpcg_pkg::LPCG_RUN;
         end
      endcase

      // ****************************************
      // Speed mode and automatic middle-speed switch
      // ****************************************
      if (go_mid_speed) begin
         next_r.mid = 1'b1;
      end else if (go_low_speed) begin
         next_r.mid = 1'b0;
         next_r.half = '0;
      end
      if (auto_mid_write) begin
         next_r.auto_en = auto_mid_value;
         if (auto_mid_value && r.mid) begin
            next_r.main_req = 1'b1;
         end
      end
      if (main_stop) begin
         next_r.main_req = 1'b0;
      end
      if (main_start) begin
         next_r.main_req = 1'b1;
      end
      if (r.auto_en && !r.mid && !r.auto_run && i2c_edge) begin
         next_r.auto_run = 1'b1;
         next_r.auto_cnt = '0;
         next_r.main_req = 1'b1;
      end
      // Count low-speed rising edges, then switch on the next falling one: half-cycle offset
      if (r.auto_run && r.st == lpcg_pkg::LPCG_RUN && src_tick) begin
         if (!r.phi && r.auto_cnt != auto_goal) begin
            next_r.auto_cnt = r.auto_cnt + 3'h1;
         end else if (r.phi && r.auto_cnt == auto_goal) begin
            next_r.auto_run = 1'b0;
            next_r.mid = 1'b1;
            next_r.half = '0;
         end
      end
      if (r.mid) begin
         next_r.auto_run = 1'b0;
      end

      // ****************************************
      // Oscillator enables: off in stop, otherwise follow rc_osc_on, main request and sub_osc_on
      // ****************************************
      next_r.rc_en = rc_osc_on && (next_r.st != lpcg_pkg::LPCG_STOP);
      next_r.main_en = next_r.main_req && (next_r.st != lpcg_pkg::LPCG_STOP);
      next_r.sub_en = sub_osc_on && (next_r.st != lpcg_pkg::LPCG_STOP);
      next_r.stop_out = (next_r.st == lpcg_pkg::LPCG_STOP) || (next_r.st == lpcg_pkg::LPCG_STAB);
      next_r.wait_out = next_r.st == lpcg_pkg::LPCG_WAIT;
   end

   // ****************************************
   // Registers; synchronous reset releases stop with no wait
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         r.st <= lpcg_pkg::LPCG_RUN;
         r.stop_pend <= 1'b0;
         r.wait_pend <= 1'b0;
         r.phi <= 1'b1;
         r.half <= '0;
         r.div16 <= '0;
         r.pre <= lpcg_pkg::PRE_INIT;
         r.tmr <= lpcg_pkg::TMR_INIT;
         r.uflow <= 1'b0;
         r.mid <= 1'b1;
         r.auto_en <= 1'b0;
         r.auto_run <= 1'b0;
         r.auto_cnt <= '0;
         r.main_req <= 1'b0;
         r.rc_en <= 1'b1;
         r.main_en <= 1'b0;
         r.sub_en <= 1'b0;
         r.stop_out <= 1'b0;
         r.wait_out <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign phi = r.phi;
   assign rc_osc_en = r.rc_en;
   assign main_osc_en = r.main_en;
   assign sub_osc_en = r.sub_en;
   assign mid_speed = r.mid;
   assign stop_active = r.stop_out;
   assign wait_active = r.wait_out;
   assign tmr_underflow = r.uflow;
   assign stab_pre = r.pre;
   assign stab_tmr = r.tmr;
endmodule

//--- test_low_power_clock_gating.sv
`timescale 1ns/1ps
module test_low_power_clock_gating;
   logic ref_clk = 1'b0, rst_b = 1'b0, rc_osc_clk = 1'b0, main_osc_input = 1'b0;
   logic sub_osc_input = 1'b0, scl_pin = 1'b0, sda_pin = 1'b0, stop_i = 1'b0, wait_i = 1'b0;
   logic ext_irq = 1'b0, irq_accepted = 1'b0, stab_select = 1'b0, auto_mid_write = 1'b0;
   logic auto_mid_value = 1'b0, auto_wait_long = 1'b0, rc_source_sel = 1'b1, rc_osc_on = 1'b1;
   logic sub_osc_on = 1'b0, main_start = 1'b0, main_stop = 1'b0, go_low_speed = 1'b0;
   logic go_mid_speed = 1'b0, stab_load = 1'b0, clr = 1'b0;
   logic [7:0] pre_v = 8'h00, tmr_v = 8'h00, stab_pre, stab_tmr;
   logic phi, rc_osc_en, main_osc_en, sub_osc_en, mid_speed, stop_active, wait_active;
   logic tmr_underflow;
   logic [15:0] pulses;
   int err_total = 0, checked = 0, cyc = 0;
   lpcg_top u_lpcg_top (
      .ref_clk(ref_clk), .rst_b(rst_b), .rc_osc_clk(rc_osc_clk), .sda_pin(sda_pin),
      .main_osc_input(main_osc_input), .sub_osc_input(sub_osc_input), .scl_pin(scl_pin),
      .stop_instruction(stop_i), .wait_instruction(wait_i), .ext_irq(ext_irq),
      .irq_accepted(irq_accepted), .stab_select(stab_select), .auto_mid_write(auto_mid_write),
      .auto_mid_value(auto_mid_value), .auto_wait_long(auto_wait_long), .rc_osc_on(rc_osc_on),
      .rc_source_sel(rc_source_sel), .sub_osc_on(sub_osc_on), .main_start(main_start),
      .main_stop(main_stop), .go_low_speed(go_low_speed), .go_mid_speed(go_mid_speed),
      .stab_load(stab_load), .stab_pre_value(pre_v), .stab_tmr_value(tmr_v), .phi(phi),
      .rc_osc_en(rc_osc_en), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
      .mid_speed(mid_speed), .stop_active(stop_active), .wait_active(wait_active),
      .tmr_underflow(tmr_underflow), .stab_pre(stab_pre), .stab_tmr(stab_tmr)
   );
   lpcg_cpu_model u_lpcg_cpu_model (.ref_clk(ref_clk), .phi(phi), .clr(clr), .pulses(pulses));
   // ****************************************
   // Clock, oscillators, timeout
   // ****************************************
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   // A disabled oscillator holds its pin low, as a stopped resonator would
   always begin
      repeat (4) @(posedge ref_clk);
      #2;
      rc_osc_clk = rc_osc_en & ~rc_osc_clk;
      main_osc_input = main_osc_en & ~main_osc_input;
      sub_osc_input = sub_osc_en & ~sub_osc_input;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 10000) begin
         err_total++;
         test_done();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic chk_b(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_v(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      chk_b("mid_speed", 1'b1, mid_speed);
      chk_b("main_osc_en", 1'b0, main_osc_en);
      pulse(clr);
      tick(512);
      chk_b("mid rate", 1'b1, pulses >= 7 && pulses <= 9);
      $display("t_reset done");
   endtask
   task automatic t_stop_rst();
      pre_v = 8'h12;
      tmr_v = 8'h34;
      pulse(stab_load);
      pulse(stop_i);
      tick(40);
      chk_b("osc off", 1'b0, rc_osc_en | main_osc_en | sub_osc_en);
      chk_v("stab_pre", 8'hFF, stab_pre);
      chk_v("stab_tmr", 8'h01, stab_tmr);
      rst_b = 1'b0;
      tick(1);
      rst_b = 1'b1;
      tick(1);
      chk_b("stop left", 1'b0, stop_active);
      chk_b("phi after reset", 1'b1, phi);
      $display("t_stop_rst done");
   endtask
   task automatic t_stop_irq();
      int n;
      pre_v = 8'h01;
      tmr_v = 8'h00;
      pulse(stab_load);
      stab_select = 1'b1;
      irq_accepted = 1'b0;
      pulse(stop_i);
      tick(40);
      chk_v("pre kept", 8'h01, stab_pre);
      chk_v("tmr kept", 8'h00, stab_tmr);
      pulse(ext_irq);
      n = 0;
      while (tmr_underflow !== 1'b1 && n < 600) begin
         tick(1);
         n++;
      end
      // Two prescaler rounds of 16 source ticks, 8 clocks each
      chk_b("stab time", 1'b1, n >= 230 && n <= 290);
      $display("t_stop_irq done");
   endtask
   task automatic t_wait();
      sub_osc_on = 1'b1;
      pulse(wait_i);
      tick(40);
      chk_b("wait_active", 1'b1, wait_active);
      chk_b("rc kept", 1'b1, rc_osc_en);
      chk_b("sub kept", 1'b1, sub_osc_en);
      pulse(irq_accepted);
      tick(1);
      chk_b("wait left", 1'b0, wait_active);
      $display("t_wait done");
   endtask
   task automatic t_auto(input logic lng, ref logic pin);
      int n;
      int w;
      // Seven or five low-speed cycles of 16 clocks, half a cycle either way, plus pin sync
      w = lng ? 112 : 80;
      pulse(go_low_speed);
      pulse(main_stop);
      pulse(clr);
      tick(320);
      chk_b("low mode", 1'b0, mid_speed);
      chk_b("low rate", 1'b1, pulses >= 19 && pulses <= 21);
      auto_wait_long = lng;
      auto_mid_value = 1'b1;
      pulse(auto_mid_write);
      pin = ~pin;
      n = 0;
      while (mid_speed !== 1'b1 && n < 300) begin
         tick(1);
         n++;
      end
      chk_b("auto main", 1'b1, main_osc_en);
      chk_b("auto delay", 1'b1, n >= w - 8 && n <= w + 16);
      $display("t_auto done");
   endtask
   task automatic t_auto_mid();
      pulse(main_stop);
      tick(2);
      chk_b("main off", 1'b0, main_osc_en);
      pulse(auto_mid_write);
      tick(3);
      chk_b("main on", 1'b1, main_osc_en & mid_speed);
      rc_source_sel = 1'b0;
      pulse(clr);
      tick(512);
      chk_b("main mid rate", 1'b1, pulses >= 7 && pulses <= 9);
      rc_source_sel = 1'b1;
      $display("t_auto_mid done");
   endtask
   task automatic test_done();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      tick(20);
      rst_b = 1'b1;
      tick(1);
      t_reset();
      t_stop_rst();
      t_stop_irq();
      t_wait();
      t_auto(1'b0, scl_pin);
      t_auto(1'b1, sda_pin);
      t_auto_mid();
      test_done();
   end
endmodule
